// ==== ocpwm_pkg.sv ====
/*
 * Constants and state types for the output compare / PWM channel.
 * Assumes a 16-bit up-counting timer outside the block.
 */
package ocpwm_pkg;

    localparam int          CNT_W           = 16;

    // Compare mode field codes
    localparam logic [2:0]  MODE_OFF        = 3'h0;
    localparam logic [2:0]  MODE_FORCE_LOW  = 3'h1;
    localparam logic [2:0]  MODE_FORCE_HIGH = 3'h2;
    localparam logic [2:0]  MODE_TOGGLE     = 3'h3;
    localparam logic [2:0]  MODE_SINGLE     = 3'h4;
    localparam logic [2:0]  MODE_CONTINUOUS = 3'h5;
    localparam logic [2:0]  MODE_PWM        = 3'h6;
    localparam logic [2:0]  MODE_PWM_FAULT  = 3'h7;

    localparam logic [2:0]  MODE_RESET      = MODE_OFF;
    localparam logic [15:0] CMP_RESET       = 16'h0000;
    localparam logic [15:0] DUTY_ZERO       = 16'h0000;
    localparam logic        TIMER_SEL_A     = 1'b0;

    typedef enum logic [2:0] {
        OCPWM_PH_IDLE       = 3'b001,
        OCPWM_PH_WAIT_START = 3'b010,
        OCPWM_PH_WAIT_STOP  = 3'b100
    } ocpwm_phase_e;

    typedef struct packed {
        logic [2:0]       mode;
        logic [CNT_W-1:0] main_cmp;
        logic [CNT_W-1:0] sec_cmp;
        logic [CNT_W-1:0] prev_count;
        logic             count_valid;
        ocpwm_phase_e     phase;
        logic             pin;
        logic             oe;
        logic             fault;
        logic             irq;
        logic             irq_a;
        logic             irq_b;
    } ocpwm_state_s;

endpackage

// ==== ocpwm_channel.sv ====
/*
 * One output compare channel: simple match, single/continuous pulse and
 * buffered PWM with optional fault shutdown.
 * Assumes the two timers, their periods and enables live outside; a
 * timer tick pulse marks the cycle in which that timer will increment.
 */
`timescale 1ns/1ps
module ocpwm_channel (
    input  wire logic        CLK_SYS_IN,
    input  wire logic        RESET_N_IN,
    input  wire logic [15:0] TIMER_A_COUNT_IN,
    input  wire logic [15:0] TIMER_B_COUNT_IN,
    input  wire logic [15:0] TIMER_A_PERIOD_IN,
    input  wire logic [15:0] TIMER_B_PERIOD_IN,
    input  wire logic        TIMER_A_TICK_IN,
    input  wire logic        TIMER_B_TICK_IN,
    input  wire logic        TIMER_A_ON_IN,
    input  wire logic        TIMER_B_ON_IN,
    input  wire logic        TIMER_A_IDLE_STOP_IN,
    input  wire logic        TIMER_B_IDLE_STOP_IN,
    input  wire logic        TIMER_SOURCE_SELECT_IN,
    input  wire logic        STOP_IN_IDLE_SELECT_IN,
    input  wire logic        CPU_IDLE_IN,
    input  wire logic        CPU_SLEEP_IN,
    input  wire logic [2:0]  COMPARE_MODE_IN,
    input  wire logic        MODE_WRITE_IN,
    input  wire logic [15:0] MAIN_COMPARE_IN,
    input  wire logic        MAIN_COMPARE_WRITE_IN,
    input  wire logic [15:0] SECONDARY_COMPARE_IN,
    input  wire logic        SECONDARY_COMPARE_WRITE_IN,
    input  wire logic        FAULT_INPUT_N_IN,
    input  wire logic        COMPARE_IRQ_CLEAR_IN,
    output logic             COMPARE_OUTPUT_PIN_OUT,
    output logic             COMPARE_OUTPUT_PIN_OE_OUT,
    output logic             FAULT_STATUS_FLAG_OUT,
    output logic             COMPARE_IRQ_FLAG_OUT,
    output logic             FIRST_TIMER_IRQ_SET_OUT,
    output logic             SECOND_TIMER_IRQ_SET_OUT,
    output logic [15:0]      MAIN_COMPARE_OUT,
    output logic [2:0]       MODE_OUT
);

    ocpwm_pkg::ocpwm_state_s st;
    ocpwm_pkg::ocpwm_state_s next_st;

    logic        sel_b;
    logic [15:0] sel_count;
    logic [15:0] sel_period;
    logic        sel_tick;
    logic        sel_on;
    logic        sel_idle_stop;
    logic        run;
    logic        new_count;
    logic        main_match;
    logic        sec_match;
    logic        period_evt;
    logic        is_pwm;
    logic        wr_pwm;

    // Timer A unless source select is set
    assign sel_b         = (TIMER_SOURCE_SELECT_IN != ocpwm_pkg::TIMER_SEL_A);
    assign sel_count     = sel_b ? TIMER_B_COUNT_IN : TIMER_A_COUNT_IN;
    assign sel_period    = sel_b ? TIMER_B_PERIOD_IN : TIMER_A_PERIOD_IN;
    assign sel_tick      = sel_b ? TIMER_B_TICK_IN : TIMER_A_TICK_IN;
    assign sel_on        = sel_b ? TIMER_B_ON_IN : TIMER_A_ON_IN;
    assign sel_idle_stop = sel_b ? TIMER_B_IDLE_STOP_IN
                                 : TIMER_A_IDLE_STOP_IN;

    // Sleep freezes matches and period events, the pin then simply holds its flop value
    assign run = !CPU_SLEEP_IN &&
                 (!CPU_IDLE_IN ||
                  (!STOP_IN_IDLE_SELECT_IN && sel_on &&
                   !sel_idle_stop));

    // A match fires once, when the count arrives at the value
    assign new_count  = !st.count_valid || (sel_count != st.prev_count);
    assign main_match = run && new_count && (sel_count == st.main_cmp);
    assign sec_match  = run && new_count && (sel_count == st.sec_cmp);
    assign period_evt = run && sel_tick && (sel_count == sel_period);
    assign is_pwm     = (st.mode == ocpwm_pkg::MODE_PWM) ||
                        (st.mode == ocpwm_pkg::MODE_PWM_FAULT);
    assign wr_pwm     = MODE_WRITE_IN &&
                        ((COMPARE_MODE_IN == ocpwm_pkg::MODE_PWM) ||
                         (COMPARE_MODE_IN == ocpwm_pkg::MODE_PWM_FAULT));

    always_comb begin
        next_st       = st;
        next_st.irq_a = 1'b0;
        next_st.irq_b = 1'b0;
        if (run) begin
            next_st.prev_count  = sel_count;
            next_st.count_valid = 1'b1;
        end
        // Main value is the duty latch in PWM, so writes are dropped
        if (MAIN_COMPARE_WRITE_IN && !is_pwm) begin
            next_st.main_cmp = MAIN_COMPARE_IN;
        end
        if (SECONDARY_COMPARE_WRITE_IN) begin
            next_st.sec_cmp = SECONDARY_COMPARE_IN;
        end
        if (COMPARE_IRQ_CLEAR_IN) begin
            next_st.irq = 1'b0;
        end
        unique case (st.mode)
            ocpwm_pkg::MODE_FORCE_LOW: begin
                if (main_match) begin
                    next_st.pin = 1'b0;
                    next_st.irq = 1'b1;
                end
            end
            ocpwm_pkg::MODE_FORCE_HIGH: begin
                if (main_match) begin
                    next_st.pin = 1'b1;
                    next_st.irq = 1'b1;
                end
            end
            ocpwm_pkg::MODE_TOGGLE: begin
                if (main_match) begin
                    next_st.pin = !st.pin;
                    next_st.irq = 1'b1;
                end
            end
            ocpwm_pkg::MODE_SINGLE,
            ocpwm_pkg::MODE_CONTINUOUS: begin
                unique case (st.phase)
                    ocpwm_pkg::OCPWM_PH_IDLE: begin
                        next_st.phase = ocpwm_pkg::OCPWM_PH_IDLE;
                    end
                    ocpwm_pkg::OCPWM_PH_WAIT_START: begin
                        if (main_match) begin
                            next_st.pin   = 1'b1;
                            next_st.irq   = 1'b1;
                            next_st.phase = ocpwm_pkg::OCPWM_PH_WAIT_STOP;
                        end
                    end
                    ocpwm_pkg::OCPWM_PH_WAIT_STOP: begin
                        if (sec_match) begin
                            next_st.pin = 1'b0;
                            next_st.irq = 1'b1;
                            // Single pulse parks until mode is rewritten
                            next_st.phase =
                                (st.mode == ocpwm_pkg::MODE_SINGLE)
                                ? ocpwm_pkg::OCPWM_PH_IDLE
                                : ocpwm_pkg::OCPWM_PH_WAIT_START;
                        end
                    end
                    default: begin
                        next_st.phase = ocpwm_pkg::OCPWM_PH_IDLE;
                    end
                endcase
            end
            ocpwm_pkg::MODE_PWM,
            ocpwm_pkg::MODE_PWM_FAULT: begin
                // Duty match clears first; a boundary in the same cycle
                // starts the next period and so takes over
                if (main_match) begin
                    next_st.pin = 1'b0;
                end
                if (period_evt) begin
                    next_st.main_cmp = st.sec_cmp;
                    // Duty above period never matches, so the pin stays set
                    next_st.pin = (st.sec_cmp != ocpwm_pkg::DUTY_ZERO);
                    next_st.irq_a = !sel_b;
                    next_st.irq_b = sel_b;
                end
                if ((st.mode == ocpwm_pkg::MODE_PWM_FAULT) &&
                    !FAULT_INPUT_N_IN) begin
                    next_st.fault = 1'b1;
                end
            end
            ocpwm_pkg::MODE_OFF: begin
                next_st.pin = st.pin;
            end
        endcase
        if (MODE_WRITE_IN) begin
            next_st.mode  = COMPARE_MODE_IN;
            next_st.phase = ocpwm_pkg::OCPWM_PH_IDLE;
            if ((COMPARE_MODE_IN == ocpwm_pkg::MODE_SINGLE) ||
                (COMPARE_MODE_IN == ocpwm_pkg::MODE_CONTINUOUS)) begin
                next_st.phase = ocpwm_pkg::OCPWM_PH_WAIT_START;
                next_st.pin   = 1'b0;
            end
            if (wr_pwm || (COMPARE_MODE_IN == ocpwm_pkg::MODE_OFF)) begin
                next_st.pin = 1'b0;
            end
            // Rearm only with the fault gone; a fresh fault still wins
            if (wr_pwm && FAULT_INPUT_N_IN) begin
                next_st.fault = 1'b0;
            end
        end
        // Pin released while shut down or with the channel off
        next_st.oe = !next_st.fault &&
                     (next_st.mode != ocpwm_pkg::MODE_OFF);
    end

    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            st.mode        <= ocpwm_pkg::MODE_RESET;
            st.main_cmp    <= ocpwm_pkg::CMP_RESET;
            st.sec_cmp     <= ocpwm_pkg::CMP_RESET;
            st.prev_count  <= ocpwm_pkg::CMP_RESET;
            st.count_valid <= 1'b0;
            st.phase       <= ocpwm_pkg::OCPWM_PH_IDLE;
            st.pin         <= 1'b0;
            st.oe          <= 1'b0;
            st.fault       <= 1'b0;
            st.irq         <= 1'b0;
            st.irq_a       <= 1'b0;
            st.irq_b       <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign COMPARE_OUTPUT_PIN_OUT    = st.pin;
    assign COMPARE_OUTPUT_PIN_OE_OUT = st.oe;
    assign FAULT_STATUS_FLAG_OUT     = st.fault;
    assign COMPARE_IRQ_FLAG_OUT      = st.irq;
    assign FIRST_TIMER_IRQ_SET_OUT   = st.irq_a;
    assign SECOND_TIMER_IRQ_SET_OUT  = st.irq_b;
    assign MAIN_COMPARE_OUT          = st.main_cmp;
    assign MODE_OUT                  = st.mode;

    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RESET_N_IN);

    sequence s_fault_hit;
        st.mode == ocpwm_pkg::MODE_PWM_FAULT && !FAULT_INPUT_N_IN &&
        !MODE_WRITE_IN;
    endsequence

    sequence s_released;
        !COMPARE_OUTPUT_PIN_OE_OUT && FAULT_STATUS_FLAG_OUT;
    endsequence

    property p_fault_release;
        s_fault_hit |=> s_released;
    endproperty
    a_fault_release: assert property (p_fault_release)
        else $error("fault did not release the pin");

    property p_fault_hold;
        st.fault && !(wr_pwm && FAULT_INPUT_N_IN) |=> st.fault && !st.oe;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault cleared without input high and rewrite");

    sequence s_boundary;
        is_pwm && period_evt && !MODE_WRITE_IN;
    endsequence

    property p_boundary;
        s_boundary |=> MAIN_COMPARE_OUT == $past(st.sec_cmp) &&
            COMPARE_OUTPUT_PIN_OUT == ($past(st.sec_cmp) != 16'h0000) &&
            (FIRST_TIMER_IRQ_SET_OUT != SECOND_TIMER_IRQ_SET_OUT);
    endproperty
    a_boundary: assert property (p_boundary)
        else $error("period boundary actions wrong");

    property p_duty_zero;
        s_boundary and (st.sec_cmp == 16'h0000) |=> !COMPARE_OUTPUT_PIN_OUT;
    endproperty
    a_duty_zero: assert property (p_duty_zero)
        else $error("zero duty drove the pin high");

    property p_pwm_no_flag;
        is_pwm && !st.irq && !MODE_WRITE_IN |=> !COMPARE_IRQ_FLAG_OUT;
    endproperty
    a_pwm_no_flag: assert property (p_pwm_no_flag)
        else $error("compare flag set in PWM");

    property p_flag_sticky;
        st.irq && !COMPARE_IRQ_CLEAR_IN |=> COMPARE_IRQ_FLAG_OUT;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("compare flag dropped without clear");

    property p_sleep_hold;
        CPU_SLEEP_IN && !MODE_WRITE_IN |=> $stable(COMPARE_OUTPUT_PIN_OUT);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("pin moved during sleep");

    property p_idle_stop;
        CPU_IDLE_IN && STOP_IN_IDLE_SELECT_IN && !MODE_WRITE_IN |=>
            $stable(COMPARE_OUTPUT_PIN_OUT) && !FIRST_TIMER_IRQ_SET_OUT;
    endproperty
    a_idle_stop: assert property (p_idle_stop)
        else $error("channel ran in idle while stopped");

    property p_force_low;
        st.mode == ocpwm_pkg::MODE_FORCE_LOW && main_match &&
        !MODE_WRITE_IN |=> !COMPARE_OUTPUT_PIN_OUT && COMPARE_IRQ_FLAG_OUT;
    endproperty
    a_force_low: assert property (p_force_low)
        else $error("force low match missed");

    property p_single_once;
        st.mode == ocpwm_pkg::MODE_SINGLE &&
        st.phase == ocpwm_pkg::OCPWM_PH_IDLE && !MODE_WRITE_IN |=>
            st.phase == ocpwm_pkg::OCPWM_PH_IDLE && !COMPARE_OUTPUT_PIN_OUT;
    endproperty
    a_single_once: assert property (p_single_once)
        else $error("single pulse rearmed without rewrite");

    property p_pulse_start;
        st.phase == ocpwm_pkg::OCPWM_PH_WAIT_START && main_match &&
        !MODE_WRITE_IN |=> COMPARE_OUTPUT_PIN_OUT ##1
            (COMPARE_OUTPUT_PIN_OUT || $past(sec_match) || $past(MODE_WRITE_IN));
    endproperty
    a_pulse_start: assert property (p_pulse_start)
        else $error("pulse did not start on main match");

    property p_toggle;
        st.mode == ocpwm_pkg::MODE_TOGGLE && main_match && !MODE_WRITE_IN |=>
            COMPARE_OUTPUT_PIN_OUT != $past(st.pin);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle match did not flip the pin");

    property p_duty_clear;
        is_pwm && main_match && !period_evt && !MODE_WRITE_IN |=>
            !COMPARE_OUTPUT_PIN_OUT;
    endproperty
    a_duty_clear: assert property (p_duty_clear)
        else $error("duty match did not clear the pin");

endmodule // ocpwm_channel

// ==== ocpwm_timer.sv ====
/*
 * Behavioural up-counting timer standing outside the channel.
 * Assumes the bench drives run, clear and period off the rising edge.
 */
`timescale 1ns/1ps
module ocpwm_timer (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        run_in,
    input  wire logic        clear_in,
    input  wire logic [15:0] period_in,
    output logic      [15:0] count_out,
    output logic             tick_out
);
    // One increment per cycle keeps every match time predictable
    assign tick_out = run_in;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_out <= 16'h0000;
        end else if (clear_in) begin
            count_out <= 16'h0000;
        end else if (tick_out) begin
            count_out <= (count_out == period_in) ? 16'h0000
                                                  : count_out + 16'h0001;
        end
    end
endmodule // ocpwm_timer

// ==== ocpwm_channel_bench.sv ====
/*
 * Self-checking bench for the compare / PWM channel.
 * Assumes the timer model ticks every cycle, so match times are fixed.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module ocpwm_channel_bench;
    logic        clk = 1'b0, rst_n = 1'b0;
    logic [15:0] cnt_a, cnt_b, main_rd;
    logic [15:0] per = 16'h0014, main_v = 16'h0000, sec_v = 16'h0000;
    logic        tick_a, tick_b, run_a = 0, run_b = 0, clr = 0, sel = 0;
    logic        sidl = 0, tidl = 0, idle = 0, sleep = 0, flt_n = 1;
    logic        mode_wr = 0, main_wr = 0, sec_wr = 0, irq_clr = 0, p;
    logic        pin, oe, flt, cirq, tirq_a, tirq_b;
    logic [2:0]  mode = 3'h0, mode_rd;
    logic [2:0]  codes [4] = '{3'h2, 3'h1, 3'h3, 3'h3};
    logic [3:0]  expv = 4'h5;
    int          fail_count = 0, checked = 0, hi, ti, ci;

    always #4 clk = ~clk;

    ocpwm_timer i_ocpwm_timer_a (.clk_in(clk), .rst_n_in(rst_n),
        .run_in(run_a & ~sleep & ~(idle & tidl)), .clear_in(clr),
        .period_in(per), .count_out(cnt_a), .tick_out(tick_a));
    ocpwm_timer i_ocpwm_timer_b (.clk_in(clk), .rst_n_in(rst_n),
        .run_in(run_b & ~sleep & ~(idle & tidl)), .clear_in(clr),
        .period_in(per), .count_out(cnt_b), .tick_out(tick_b));

    ocpwm_channel i_ocpwm_channel (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n),
        .TIMER_A_COUNT_IN(cnt_a), .TIMER_B_COUNT_IN(cnt_b),
        .TIMER_A_PERIOD_IN(per), .TIMER_B_PERIOD_IN(per),
        .TIMER_A_TICK_IN(tick_a), .TIMER_B_TICK_IN(tick_b),
        .TIMER_A_ON_IN(run_a), .TIMER_B_ON_IN(run_b),
        .TIMER_A_IDLE_STOP_IN(tidl), .TIMER_B_IDLE_STOP_IN(tidl),
        .TIMER_SOURCE_SELECT_IN(sel), .STOP_IN_IDLE_SELECT_IN(sidl),
        .CPU_IDLE_IN(idle), .CPU_SLEEP_IN(sleep),
        .COMPARE_MODE_IN(mode), .MODE_WRITE_IN(mode_wr),
        .MAIN_COMPARE_IN(main_v), .MAIN_COMPARE_WRITE_IN(main_wr),
        .SECONDARY_COMPARE_IN(sec_v), .SECONDARY_COMPARE_WRITE_IN(sec_wr),
        .FAULT_INPUT_N_IN(flt_n), .COMPARE_IRQ_CLEAR_IN(irq_clr),
        .COMPARE_OUTPUT_PIN_OUT(pin), .COMPARE_OUTPUT_PIN_OE_OUT(oe),
        .FAULT_STATUS_FLAG_OUT(flt), .COMPARE_IRQ_FLAG_OUT(cirq),
        .FIRST_TIMER_IRQ_SET_OUT(tirq_a),
        .SECOND_TIMER_IRQ_SET_OUT(tirq_b),
        .MAIN_COMPARE_OUT(main_rd), .MODE_OUT(mode_rd));

    task automatic wr_mode(input logic [2:0] m);
        mode = m;
        mode_wr = 1'b1;
        @(negedge clk);
        mode_wr = 1'b0;
    endtask

    // Timers stopped and cleared while values load, then mode is written
    task automatic cfg(input logic [2:0] m, input logic [15:0] mv, sv, pv);
        run_a = 1'b0;
        run_b = 1'b0;
        clr = 1'b1;
        per = pv;
        main_v = mv;
        sec_v = sv;
        main_wr = 1'b1;
        sec_wr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        main_wr = 1'b0;
        sec_wr = 1'b0;
        wr_mode(m);
    endtask

    task automatic go();
        run_a = ~sel;
        run_b = sel;
    endtask

    task automatic run_for(input int n);
        hi = 0;
        ti = 0;
        ci = 0;
        repeat (n) begin
            @(negedge clk);
            hi += pin;
            ti += sel ? tirq_b : tirq_a;
            ci += cirq;
        end
    endtask

    task automatic clr_irq();
        run_a = 1'b0;
        run_b = 1'b0;
        irq_clr = 1'b1;
        @(negedge clk);
        irq_clr = 1'b0;
        `CHK("cirq_clr", 1'b0, cirq)
    endtask

    // Period 9 spans ten samples; the pin is high for duty+1 of them at duty 1 to 9, for none at duty 0 and all ten above 9
    task automatic duty(input logic [15:0] d, input int exp_hi);
        sec_v = d;
        sec_wr = 1'b1;
        @(negedge clk);
        sec_wr = 1'b0;
        run_for(10);
        run_for(40);
        `CHK("pwm_hi", exp_hi, hi)
        `CHK("pwm_tirq", 4, ti)
        `CHK("pwm_cirq", 0, ci)
        `CHK("duty_latch", d, main_rd)
    endtask

    task automatic wrap_up;
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        `CHK("mode_rst", 3'h0, mode_rd)
        `CHK("oe_rst", 1'b0, oe)
        `CHK("cirq_rst", 1'b0, cirq)
        for (int i = 0; i < 4; i++) begin
            sel = (i == 3);
            cfg(codes[i], 16'h0005, 16'h0000, 16'h0014);
            go();
            run_for(5);
            `CHK("pin_pre", ~expv[i], pin)
            run_for(1);
            `CHK("pin_match", expv[i], pin)
            `CHK("cirq_set", 1'b1, cirq)
            clr_irq();
        end
        sel = 1'b0;
        cfg(3'h2, 16'h001e, 16'h0000, 16'h000a);
        go();
        run_for(30);
        `CHK("wrap_hold", 0, hi)
        `CHK("wrap_cirq", 0, ci)
        cfg(3'h4, 16'h0003, 16'h0007, 16'h0014);
        go();
        run_for(30);
        `CHK("single_hi", 4, hi)
        `CHK("single_cirq", 27, ci)
        run_for(30);
        `CHK("single_once", 0, hi)
        wr_mode(3'h4);
        run_for(30);
        `CHK("single_again", 4, hi)
        cfg(3'h5, 16'h0003, 16'h0007, 16'h0014);
        go();
        run_for(42);
        `CHK("cont_hi", 8, hi)
        clr_irq();
        cfg(3'h6, 16'h0000, 16'h0004, 16'h0009);
        go();
        duty(16'h0004, 20);
        main_v = 16'h0003;
        main_wr = 1'b1;
        @(negedge clk);
        main_wr = 1'b0;
        `CHK("main_ro", 16'h0004, main_rd)
        duty(16'h0007, 32);
        duty(16'h0000, 0);
        duty(16'h000c, 40);
        cfg(3'h7, 16'h0000, 16'h0004, 16'h0009);
        go();
        run_for(15);
        flt_n = 1'b0;
        @(negedge clk);
        `CHK("flt_set", 1'b1, flt)
        `CHK("flt_oe", 1'b0, oe)
        flt_n = 1'b1;
        run_for(5);
        `CHK("flt_hold", 1'b1, flt)
        wr_mode(3'h3);
        `CHK("flt_nonpwm", 1'b1, flt)
        flt_n = 1'b0;
        @(negedge clk);
        wr_mode(3'h7);
        flt_n = 1'b1;
        @(negedge clk);
        `CHK("flt_lowwr", 1'b1, flt)
        wr_mode(3'h7);
        `CHK("flt_clr", 1'b0, flt)
        `CHK("flt_oe_on", 1'b1, oe)
        `CHK("mode_rd", 3'h7, mode_rd)
        // Sleep, channel idle stop, timer idle stop, then idle running
        for (int i = 0; i < 4; i++) begin
            sleep = (i == 0);
            idle = (i > 0);
            sidl = (i == 1);
            tidl = (i == 2);
            p = pin;
            run_for(30);
            if (i < 3) begin
                `CHK("frozen_pin", p ? 30 : 0, hi)
                `CHK("frozen_tirq", 0, ti)
            end
            sleep = 1'b0;
            idle = (i == 3);
            sidl = 1'b0;
            tidl = 1'b0;
            run_for(10);
            run_for(40);
            `CHK("resume_hi", 20, hi)
        end
        // PWM again on timer B, so its irq set pulse is seen
        idle = 1'b0;
        clr_irq();
        sel = 1'b1;
        cfg(3'h6, 16'h0000, 16'h0004, 16'h0009);
        go();
        duty(16'h0004, 20);
        wrap_up();
    end
endmodule // ocpwm_channel_bench
